/* File: timer_and_ext_irq_control_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module timer_and_ext_irq_control_tb
   import tmc_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   tmc_pins_t   pins;
   logic [3:0]  ack_v = 4'h0;
   logic [4:0]  irq_req;
   logic        rx_tick;
   logic        tx_tick;
   logic        irq;
   logic [6:0]  watch;
   logic [31:0] rdv;
   logic        rerr;
   int          fails = 0;
   int          samples_checked = 0;
   int          seed = 32'h6507;
   logic [31:0] rnd;

   assign watch = {tx_tick, rx_tick, irq_req};
   always #4 pclk = ~pclk;

   tmc_pins_model pm (.pclk(pclk), .pins(pins));

   // A short tick divider keeps each wrap from a loaded 16'hfffe within a few dozen cycles.
   tmc_timer_irq_ctrl #(.TICK_DIV(4'h2)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .irq_taken(ack_v), .irq_request(irq_req), .rx_baud_tick(rx_tick),
      .tx_baud_tick(tx_tick), .irq(irq));

   task automatic tally_and_finish;
      if (fails == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // Read data stands from setup to the next setup, so taking it at this edge is safe.
      rdv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Flag and tick outputs are looked at on the falling edge, where they have settled.
   task automatic wait_on(input int b);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (watch[b] !== 1'b1 && n < 300);
      if (n >= 300) begin
         fails++;
         tally_and_finish();
      end
   endtask

   task automatic ack(input logic [3:0] v);
      @(posedge pclk);
      ack_v <= v;
      @(posedge pclk);
      ack_v <= 4'h0;
   endtask

   task automatic pin_pulse(input int idx);
      pm.set(idx, 1'b0);
      pm.set(idx, 1'b1);
   endtask

   initial begin
      repeat (100000) @(posedge pclk);
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(TMC_OFS_TIMER_AND_IRQ_CONTROL);
      `CHK(rdv, 0);
      rd(TMC_OFS_TIMER_TWO_CONTROL);
      `CHK(rdv, 0);
      rd(12'h0fc);
      `CHK(rerr, 1'b1);
      `CHK(rdv, 32'h0000_0000);
      rnd = $random(seed);
      wr(TMC_OFS_IRQ_MASK, rnd);
      rd(TMC_OFS_IRQ_MASK);
      `CHK(rdv, rnd[5:0]);
      wr(TMC_OFS_IRQ_MASK, 32'h0000_0001);
      // Timers zero and one share one sequence; only timer zero is unmasked.
      for (int t = 0; t < 2; t++) begin
         wr(TMC_OFS_TIMER_ZERO_COUNT + 12'(4 * t), 32'h0000_fffe);
         wr(TMC_OFS_TIMER_AND_IRQ_CONTROL, 32'(1 << (4 + 2 * t)));
         wait_on(2 * t);
         @(negedge pclk);
         `CHK(irq, t == 0);
         rd(TMC_OFS_TIMER_AND_IRQ_CONTROL);
         `CHK(rdv, 3 << (4 + 2 * t));
         ack(4'(1 << (2 * t)));
         rd(TMC_OFS_TIMER_AND_IRQ_CONTROL);
         `CHK(rdv, 1 << (4 + 2 * t));
         rd(TMC_OFS_IRQ_STATUS);
         `CHK(rdv, 1 << (2 * t));
         rd(TMC_OFS_IRQ_STATUS);
         `CHK(rdv, 0);
         wr(TMC_OFS_TIMER_AND_IRQ_CONTROL, 32'h0000_0000);
         rd(TMC_OFS_TIMER_ZERO_COUNT + 12'(4 * t));
         rnd = rdv;
         repeat (10) @(posedge pclk);
         rd(TMC_OFS_TIMER_ZERO_COUNT + 12'(4 * t));
         `CHK(rdv, rnd);
      end
      // A low level keeps re-arming the flag even across an acknowledge.
      pm.set(0, 1'b0);
      wait_on(1);
      ack(4'h2);
      repeat (2) @(negedge pclk);
      `CHK(irq_req[1], 1);
      pm.set(0, 1'b1);
      ack(4'h2);
      repeat (2) @(negedge pclk);
      `CHK(irq_req[1], 0);
      wr(TMC_OFS_TIMER_AND_IRQ_CONTROL, 32'h0000_0004);
      pm.set(1, 1'b0);
      wait_on(3);
      ack(4'h8);
      repeat (4) @(posedge pclk);
      rd(TMC_OFS_TIMER_AND_IRQ_CONTROL);
      `CHK(rdv, 32'h0000_0004);
      pm.set(1, 1'b1);
      rd(TMC_OFS_IRQ_STATUS);
      `CHK(rdv, 32'h0000_000a);
      // Timer two overflow is cleared by software only.
      wr(TMC_OFS_TIMER_TWO_COUNT, 32'h0000_fffe);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0004);
      wait_on(4);
      ack(4'hf);
      rd(TMC_OFS_TIMER_TWO_CONTROL);
      `CHK(rdv, 32'h0000_0084);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0000);
      rd(TMC_OFS_TIMER_TWO_CONTROL);
      `CHK(rdv, 0);
      for (int b = 5; b > 3; b--) begin
         wr(TMC_OFS_TIMER_TWO_COUNT, 32'h0000_fffe);
         wr(TMC_OFS_TIMER_TWO_CONTROL, 32'(1 << b | 4));
         wait_on(10 - b);
         `CHK(watch[10 - b], 1);
         rd(TMC_OFS_TIMER_TWO_CONTROL);
         `CHK(rdv, 1 << b | 4);
      end
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0000);
      wr(TMC_OFS_TIMER_TWO_COUNT, 32'h0000_0abc);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0009);
      pin_pulse(2);
      repeat (3) @(posedge pclk);
      rd(TMC_OFS_TIMER_TWO_RELOAD);
      `CHK(rdv, 32'h0000_0abc);
      rd(TMC_OFS_TIMER_TWO_CONTROL);
      `CHK(rdv, 32'h0000_0049);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0008);
      wr(TMC_OFS_TIMER_TWO_RELOAD, 32'h0000_5555);
      pin_pulse(2);
      repeat (3) @(posedge pclk);
      rd(TMC_OFS_TIMER_TWO_COUNT);
      `CHK(rdv, 32'h0000_5555);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0001);
      wr(TMC_OFS_TIMER_TWO_COUNT, 32'h0000_0010);
      pin_pulse(2);
      repeat (3) @(posedge pclk);
      rd(TMC_OFS_TIMER_TWO_RELOAD);
      `CHK(rdv, 32'h0000_5555);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0006);
      repeat (3) pin_pulse(2);
      repeat (3) @(posedge pclk);
      rd(TMC_OFS_TIMER_TWO_COUNT);
      `CHK(rdv, 32'h0000_0013);
      wr(TMC_OFS_TIMER_TWO_CONTROL, 32'h0000_0002);
      pin_pulse(2);
      repeat (3) @(posedge pclk);
      rd(TMC_OFS_TIMER_TWO_COUNT);
      `CHK(rdv, 32'h0000_0013);
      tally_and_finish();
   end
endmodule

/* File: tmc_pins_model.sv */
`timescale 1ns/1ps
module tmc_pins_model
   import tmc_pkg::*;
(
   // Clock
   input  wire logic pclk,
   // Pin levels towards the block
   output tmc_pins_t pins
);
   initial pins = TMC_PINS_IDLE;

   // Levels move just after a rising edge so the block never samples a changing pin.
   task automatic set(input int idx, input logic lvl);
      @(posedge pclk);
      pins[idx] <= lvl;
   endtask
endmodule

/* File: tmc_pkg.sv */
package tmc_pkg;

   // APB address width and timer width.
   localparam int unsigned TMC_ADDR_W  = 12;
   localparam int unsigned TMC_TIMER_W = 16;

   // Register byte offsets.
   localparam logic [11:0] TMC_OFS_TIMER_AND_IRQ_CONTROL = 12'h088;
   localparam logic [11:0] TMC_OFS_TIMER_TWO_CONTROL     = 12'h0c8;
   localparam logic [11:0] TMC_OFS_IRQ_STATUS            = 12'h000;
   localparam logic [11:0] TMC_OFS_IRQ_MASK              = 12'h004;
   localparam logic [11:0] TMC_OFS_TIMER_ZERO_COUNT      = 12'h010;
   localparam logic [11:0] TMC_OFS_TIMER_ONE_COUNT       = 12'h014;
   localparam logic [11:0] TMC_OFS_TIMER_TWO_COUNT       = 12'h018;
   localparam logic [11:0] TMC_OFS_TIMER_TWO_RELOAD      = 12'h01c;

   // Core clock cycles per interval-timer tick.
   localparam logic [3:0] TMC_TICK_DIV = 4'hc;

   // Field layout of the timer and interrupt control register, bit 7 first.
   typedef struct packed {
      logic timer_one_overflow_flag;
      logic timer_one_run;
      logic timer_zero_overflow_flag;
      logic timer_zero_run;
      logic ext_irq_one_flag;
      logic ext_irq_one_edge_select;
      logic ext_irq_zero_flag;
      logic ext_irq_zero_edge_select;
   } tmc_timer_and_irq_control_t;

   // Field layout of the timer two control register, bit 7 first.
   typedef struct packed {
      logic timer_two_overflow_flag;
      logic timer_two_external_flag;
      logic rx_baud_from_timer_two;
      logic tx_baud_from_timer_two;
      logic timer_two_external_enable;
      logic timer_two_run;
      logic timer_two_counter_select;
      logic timer_two_capture_select;
   } tmc_timer_two_control_t;

   // Layout of the sticky status and mask registers, bit 5 first.
   typedef struct packed {
      logic t2_ext;
      logic t2_ovf;
      logic ext_one;
      logic t1_ovf;
      logic ext_zero;
      logic t0_ovf;
   } tmc_events_t;

   typedef struct packed {
      logic timer_two_capture_pin;
      logic ext_irq_one_pin;
      logic ext_irq_zero_pin;
   } tmc_pins_t;

   // One-cycle pulses from the core when it takes an interrupt.
   typedef struct packed {
      logic ext_one;
      logic timer_one;
      logic ext_zero;
      logic timer_zero;
   } tmc_ack_t;

   // Interrupt request levels towards the core.
   typedef struct packed {
      logic timer_two;
      logic ext_one;
      logic timer_one;
      logic ext_zero;
      logic timer_zero;
   } tmc_irq_t;

   typedef struct packed {
      tmc_timer_and_irq_control_t   timer_and_irq_control;
      tmc_timer_two_control_t  timer_two_control;
      tmc_events_t status;
      tmc_events_t mask;
      logic [15:0] reload;
      logic [31:0] prdata;
      logic        pslverr;
      tmc_pins_t   pin_prev;
      logic [3:0]  div;
      logic        rx_tick;
      logic        tx_tick;
   } tmc_state_t;

   localparam tmc_timer_and_irq_control_t   TMC_TIMER_AND_IRQ_CONTROL_RESET   = 8'h00;
   localparam tmc_timer_two_control_t  TMC_TIMER_TWO_CONTROL_RESET  = 8'h00;
   localparam tmc_events_t TMC_EVENTS_RESET = 6'h00;
   localparam tmc_pins_t   TMC_PINS_IDLE    = 3'h7;
   localparam logic [15:0] TMC_RELOAD_RESET = 16'h0000;
   localparam logic [15:0] TMC_COUNT_RESET  = 16'h0000;

   localparam tmc_state_t TMC_STATE_RESET = '{
      timer_and_irq_control:     TMC_TIMER_AND_IRQ_CONTROL_RESET,
      timer_two_control:    TMC_TIMER_TWO_CONTROL_RESET,
      status:   TMC_EVENTS_RESET,
      mask:     TMC_EVENTS_RESET,
      reload:   TMC_RELOAD_RESET,
      prdata:   32'h0000_0000,
      pslverr:  1'b0,
      pin_prev: TMC_PINS_IDLE,
      div:      4'h0,
      rx_tick:  1'b0,
      tx_tick:  1'b0
   };

endpackage

/* File: tmc_timer16.sv */
`timescale 1ns/1ps
module tmc_timer16
   import tmc_pkg::*;
#(
   parameter int unsigned WIDTH = TMC_TIMER_W
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             count_en,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] load_value,
   // Status
   output logic      [WIDTH-1:0] count,
   output logic                  wrap
);

   typedef struct packed {
      logic [WIDTH-1:0] value;
   } tmc_tmr_state_t;

   tmc_tmr_state_t s;
   tmc_tmr_state_t next_s;

   // Wrap does not look at load, so a reload on wrap forms no loop.
   assign wrap  = count_en & (&s.value);
   assign count = s.value;

   always_comb begin
      next_s = s;
      if (load) begin
         next_s.value = load_value;
      end else if (count_en) begin
         next_s.value = s.value + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.value <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

/* File: tmc_timer_irq_ctrl.sv */
`timescale 1ns/1ps
module tmc_timer_irq_ctrl
   import tmc_pkg::*;
#(
   parameter logic [3:0] TICK_DIV = TMC_TICK_DIV
) (
   // Clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [TMC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // External pins
   input  wire tmc_pins_t             pins,
   // Core interrupt controller
   input  wire tmc_ack_t              irq_taken,
   output tmc_irq_t                   irq_request,
   // Serial port baud clocks
   output logic                       rx_baud_tick,
   output logic                       tx_baud_tick,
   // Summary interrupt
   output logic                       irq
);

   tmc_state_t  s;
   tmc_state_t  next_s;
   tmc_events_t ev;

   logic        setup;
   logic        access;
   logic        wr;
   logic        wr_timer_and_irq_control;
   logic        wr_timer_two_control;
   logic        wr_mask;
   logic        wr_reload;
   logic        rd_status;
   logic        tick;
   logic        fall_zero;
   logic        fall_one;
   logic        fall_cap;
   logic        t2_baud;
   logic        t2_ext_fall;
   logic        t2_capture;
   logic [2:0]  tmr_en;
   logic [2:0]  tmr_load;
   logic [2:0]  tmr_wrap;
   logic [15:0] tmr_value [3];
   logic [15:0] tmr_count [3];

   assign setup     = psel & ~penable;
   assign access    = psel & penable;
   assign wr        = access & pwrite;
   assign wr_timer_and_irq_control   = wr & (paddr == TMC_OFS_TIMER_AND_IRQ_CONTROL);
   assign wr_timer_two_control  = wr & (paddr == TMC_OFS_TIMER_TWO_CONTROL);
   assign wr_mask   = wr & (paddr == TMC_OFS_IRQ_MASK);
   assign wr_reload = wr & (paddr == TMC_OFS_TIMER_TWO_RELOAD);
   assign rd_status = access & ~pwrite & (paddr == TMC_OFS_IRQ_STATUS);

   assign tick = (s.div == TICK_DIV - 4'h1);

   // Pins are synchronous to pclk, so one stage of history gives the edge.
   assign fall_zero = s.pin_prev.ext_irq_zero_pin & ~pins.ext_irq_zero_pin;
   assign fall_one  = s.pin_prev.ext_irq_one_pin & ~pins.ext_irq_one_pin;
   assign fall_cap  = s.pin_prev.timer_two_capture_pin & ~pins.timer_two_capture_pin;

   assign t2_baud     = s.timer_two_control.rx_baud_from_timer_two | s.timer_two_control.tx_baud_from_timer_two;
   assign t2_ext_fall = s.timer_two_control.timer_two_external_enable & fall_cap;
   assign t2_capture  = s.timer_two_control.timer_two_capture_select & ~t2_baud;

   // Timers zero and one have no mode select; each counts once per tick while its run bit is set.
   assign tmr_en[0] = s.timer_and_irq_control.timer_zero_run & tick;
   assign tmr_en[1] = s.timer_and_irq_control.timer_one_run & tick;
   assign tmr_en[2] = s.timer_two_control.timer_two_run &
                      (s.timer_two_control.timer_two_counter_select ? fall_cap : tick);

   assign tmr_load[0] = wr & (paddr == TMC_OFS_TIMER_ZERO_COUNT);
   assign tmr_load[1] = wr & (paddr == TMC_OFS_TIMER_ONE_COUNT);
   // Reload mode reloads on wrap and on a qualified pin fall.
   assign tmr_load[2] = (wr & (paddr == TMC_OFS_TIMER_TWO_COUNT)) |
                        (~t2_capture & (tmr_wrap[2] | t2_ext_fall));

   assign tmr_value[0] = pwdata[15:0];
   assign tmr_value[1] = pwdata[15:0];
   assign tmr_value[2] = (wr & (paddr == TMC_OFS_TIMER_TWO_COUNT)) ? pwdata[15:0] : s.reload;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tmr
         tmc_timer16 #(
            .WIDTH      (TMC_TIMER_W)
         ) u_tmr (
            .pclk       (pclk),
            .presetn    (presetn),
            .count_en   (tmr_en[gi]),
            .load       (tmr_load[gi]),
            .load_value (tmr_value[gi]),
            .count      (tmr_count[gi]),
            .wrap       (tmr_wrap[gi])
         );
      end
   endgenerate

   assign ev.t0_ovf   = tmr_wrap[0];
   assign ev.t1_ovf   = tmr_wrap[1];
   assign ev.ext_zero = s.timer_and_irq_control.ext_irq_zero_edge_select ? fall_zero : ~pins.ext_irq_zero_pin;
   assign ev.ext_one  = s.timer_and_irq_control.ext_irq_one_edge_select ? fall_one : ~pins.ext_irq_one_pin;
   assign ev.t2_ovf   = tmr_wrap[2] & ~t2_baud;
   assign ev.t2_ext   = t2_ext_fall;

   always_comb begin
      next_s     = s;
      next_s.div = tick ? 4'h0 : s.div + 4'h1;
      next_s.pin_prev = pins;

      // Software writes first; hardware sets are ORed in afterwards so they win.
      if (wr_timer_and_irq_control) begin
         next_s.timer_and_irq_control = tmc_timer_and_irq_control_t'(pwdata[7:0]);
      end
      next_s.timer_and_irq_control.timer_zero_overflow_flag = ev.t0_ovf |
         (next_s.timer_and_irq_control.timer_zero_overflow_flag & ~irq_taken.timer_zero);
      next_s.timer_and_irq_control.timer_one_overflow_flag = ev.t1_ovf |
         (next_s.timer_and_irq_control.timer_one_overflow_flag & ~irq_taken.timer_one);
      next_s.timer_and_irq_control.ext_irq_zero_flag = ev.ext_zero |
         (next_s.timer_and_irq_control.ext_irq_zero_flag & ~irq_taken.ext_zero);
      next_s.timer_and_irq_control.ext_irq_one_flag = ev.ext_one |
         (next_s.timer_and_irq_control.ext_irq_one_flag & ~irq_taken.ext_one);

      if (wr_timer_two_control) begin
         next_s.timer_two_control = tmc_timer_two_control_t'(pwdata[7:0]);
      end
      next_s.timer_two_control.timer_two_overflow_flag = ev.t2_ovf | next_s.timer_two_control.timer_two_overflow_flag;
      next_s.timer_two_control.timer_two_external_flag = ev.t2_ext | next_s.timer_two_control.timer_two_external_flag;

      // Only the bits that the read returned are cleared, so an event landing
      // between the setup and access cycles survives.
      next_s.status = tmc_events_t'((s.status & ~(rd_status ? s.prdata[5:0] : 6'h00)) | ev);
      if (wr_mask) begin
         next_s.mask = tmc_events_t'(pwdata[5:0]);
      end

      // A hardware capture overrides a software write in the same cycle.
      if (t2_ext_fall && t2_capture) begin
         next_s.reload = tmr_count[2];
      end else if (wr_reload) begin
         next_s.reload = pwdata[15:0];
      end

      next_s.rx_tick = tmr_wrap[2] & s.timer_two_control.rx_baud_from_timer_two;
      next_s.tx_tick = tmr_wrap[2] & s.timer_two_control.tx_baud_from_timer_two;

      // Read data is captured in the setup cycle so it comes from a flop.
      if (setup) begin
         next_s.pslverr = 1'b0;
         if (paddr == TMC_OFS_TIMER_AND_IRQ_CONTROL) begin
            next_s.prdata = {24'h00_0000, s.timer_and_irq_control};
         end else if (paddr == TMC_OFS_TIMER_TWO_CONTROL) begin
            next_s.prdata = {24'h00_0000, s.timer_two_control};
         end else if (paddr == TMC_OFS_IRQ_STATUS) begin
            next_s.prdata = {26'h000_0000, s.status};
         end else if (paddr == TMC_OFS_IRQ_MASK) begin
            next_s.prdata = {26'h000_0000, s.mask};
         end else if (paddr == TMC_OFS_TIMER_ZERO_COUNT) begin
            next_s.prdata = {16'h0000, tmr_count[0]};
         end else if (paddr == TMC_OFS_TIMER_ONE_COUNT) begin
            next_s.prdata = {16'h0000, tmr_count[1]};
         end else if (paddr == TMC_OFS_TIMER_TWO_COUNT) begin
            next_s.prdata = {16'h0000, tmr_count[2]};
         end else if (paddr == TMC_OFS_TIMER_TWO_RELOAD) begin
            next_s.prdata = {16'h0000, s.reload};
         end else begin
            next_s.prdata  = 32'h0000_0000;
            next_s.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= TMC_STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign prdata       = s.prdata;
   assign pready       = 1'b1;
   assign pslverr      = s.pslverr;
   assign rx_baud_tick = s.rx_tick;
   assign tx_baud_tick = s.tx_tick;
   assign irq          = |(s.status & s.mask);

   assign irq_request.timer_zero = s.timer_and_irq_control.timer_zero_overflow_flag;
   assign irq_request.timer_one  = s.timer_and_irq_control.timer_one_overflow_flag;
   assign irq_request.ext_zero   = s.timer_and_irq_control.ext_irq_zero_flag;
   assign irq_request.ext_one    = s.timer_and_irq_control.ext_irq_one_flag;
   assign irq_request.timer_two  = s.timer_two_control.timer_two_overflow_flag | s.timer_two_control.timer_two_external_flag;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_capture_fall;
      t2_ext_fall && t2_capture;
   endsequence

   sequence seq_reload_fall;
      t2_ext_fall && !t2_capture && !wr;
   endsequence

   a_t0_ovf_set: assert property (tmr_wrap[0] |=> s.timer_and_irq_control.timer_zero_overflow_flag)
      else $error("timer zero wrap did not set its flag");

   a_t1_ack_clear: assert property (irq_taken.timer_one && !tmr_wrap[1] |=> !s.timer_and_irq_control.timer_one_overflow_flag)
      else $error("timer one flag survived interrupt taken");

   a_t1_hold_stopped: assert property (!s.timer_and_irq_control.timer_one_run && !tmr_load[1] |=> $stable(tmr_count[1]))
      else $error("timer one moved while stopped");

   a_e1_level_trig: assert property (!s.timer_and_irq_control.ext_irq_one_edge_select && !pins.ext_irq_one_pin
                                     |=> s.timer_and_irq_control.ext_irq_one_flag && s.status.ext_one)
      else $error("low level on external one did not set flag");

   a_e0_edge_quiet: assert property (s.timer_and_irq_control.ext_irq_zero_edge_select && !fall_zero && !wr_timer_and_irq_control &&
                                     !s.timer_and_irq_control.ext_irq_zero_flag |=> !s.timer_and_irq_control.ext_irq_zero_flag)
      else $error("external zero flag set without a falling edge");

   a_t2_baud_no_ovf: assert property (t2_baud && !wr_timer_two_control && !s.timer_two_control.timer_two_overflow_flag
                                      |=> !s.timer_two_control.timer_two_overflow_flag)
      else $error("timer two overflow flag set in baud mode");

   a_t2_capture_val: assert property (seq_capture_fall |=> s.reload == $past(tmr_count[2]) &&
                                      s.timer_two_control.timer_two_external_flag)
      else $error("capture did not store count or set external flag");

   a_t2_reload_val: assert property (seq_reload_fall |=> tmr_count[2] == $past(s.reload))
      else $error("pin fall did not reload timer two");

   a_t2_stop_hold: assert property (!s.timer_two_control.timer_two_run && !tmr_load[2] |=> $stable(tmr_count[2]))
      else $error("timer two moved while stopped");

   a_tx_baud_tick: assert property (tmr_wrap[2] && s.timer_two_control.tx_baud_from_timer_two
                                    |=> tx_baud_tick ##1 !tx_baud_tick || tmr_wrap[2])
      else $error("transmit baud tick missing");

   a_set_beats_ack: assert property (tmr_wrap[0] && irq_taken.timer_zero
                                     |=> s.timer_and_irq_control.timer_zero_overflow_flag ##1 s.status.t0_ovf || rd_status)
      else $error("timer zero event lost to simultaneous clear");

endmodule
